// ==== i2c_cmdseq_regs.svh ====
// constants for the command-sequenced two-wire controller
`ifndef I2C_CMDSEQ_REGS_SVH
`define I2C_CMDSEQ_REGS_SVH
`define CLK_PERIOD_NS 25
`define SCL_QTR_NS    2500
`define SCL_QTR_CYC   ((`SCL_QTR_NS) / (`CLK_PERIOD_NS))
`define NUM_CMDS      16
`define RAM_DEPTH     32
`define OP_START      3'h0
`define OP_WRITE      3'h1
`define OP_READ       3'h2
`define OP_STOP       3'h3
`define OP_END        3'h4
`define BIT_ACK       4'h8
`define BIT_END       4'h9
`define CLEAR_PULSES  4'h9
`define WIDE_PREFIX   5'h1E
`define REG_MAX_BYTES 8'h20
`define PH_DRIVE      2'h0
`define PH_RISE       2'h1
`define PH_HIGH       2'h2
`define PH_FALL       2'h3
`endif

// ==== i2c_cmdseq_pkg.sv ====
// types shared by the command-sequenced two-wire controller
package i2c_cmdseq_pkg;
  typedef struct packed {
    logic [2:0] command_code;
    logic       ack_to_send;
    logic       expected_ack;
    logic       ack_compare_enable;
    logic [7:0] byte_count;
  } cmd_t;
  typedef struct packed {
    logic tx_drained_event;
    logic rx_filled_event;
    logic ack_mismatch_event;
    logic arbitration_lost_event;
    logic transfer_done_event;
    logic pause_reached_event;
  } events_t;
  typedef enum logic [6:0] {
    M_IDLE = 7'h01, M_START = 7'h02, M_FETCH = 7'h04, M_BYTE = 7'h08,
    M_STOP = 7'h10, M_PAUSE = 7'h20, M_CLEAR = 7'h40
  } m_state_t;
  typedef enum logic [5:0] {
    S_IDLE = 6'h01, S_ADDR = 6'h02, S_ADDR2 = 6'h04, S_REG = 6'h08,
    S_RX = 6'h10, S_TX = 6'h20
  } s_state_t;
endpackage

// ==== i2c_cmdseq.sv ====
// command-list two-wire master and addressed target with shared data ram
`timescale 1ns/1ps
`include "i2c_cmdseq_regs.svh"
module i2c_cmdseq
  import i2c_cmdseq_pkg::*;
(
  // clock and reset
  input  wire logic                 i_clk_sys,
  input  wire logic                 i_rst,
  // control and configuration
  input  wire logic                 i_master_mode,
  input  wire logic                 i_begin_transaction,
  input  wire cmd_t [`NUM_CMDS-1:0] i_cmd_list,
  input  wire logic [7:0]           i_tx_threshold,
  input  wire logic [7:0]           i_rx_threshold,
  input  wire logic [9:0]           i_own_target_address,
  input  wire logic                 i_wide_address_enable,
  input  wire logic                 i_register_address_mode,
  // software ram port
  input  wire logic                 i_ram_we,
  input  wire logic [4:0]           i_ram_addr,
  input  wire logic [7:0]           i_ram_wdata,
  output logic      [7:0]           o_ram_rdata,
  // bus lines, oe high pulls the line low
  input  wire logic                 i_scl,
  input  wire logic                 i_sda,
  output logic                      o_scl_oe,
  output logic                      o_sda_oe,
  // status
  output logic [`NUM_CMDS-1:0]      o_cmd_finished,
  output logic [4:0]                o_tx_last_address,
  output logic [4:0]                o_rx_first_address,
  output logic [4:0]                o_rx_last_address,
  output events_t                   o_events,
  output logic                      o_busy
);
  logic [7:0] ram [`RAM_DEPTH];
  logic scl_a_q, scl_b_q, scl_c_q, sda_a_q, sda_b_q, sda_c_q;
  logic [7:0] qcnt_q;
  logic       tick;
  // master state
  m_state_t ms_q, ms_d;
  logic [1:0] ph_q, ph_d;
  logic [3:0] idx_q, idx_d, bit_q, bit_d, clr_q, clr_d;
  logic [7:0] cnt_q, cnt_d, sh_q, sh_d, txn_q, txn_d;
  logic [4:0] wptr_q, wptr_d, rptr_q, rptr_d, txl_q, txl_d;
  logic pend_q, pend_d, ackv_q, ackv_d, m_scl_q, m_scl_d, m_sda_q, m_sda_d;
  logic [`NUM_CMDS-1:0] fin_q, fin_d;
  events_t mev, sev;
  cmd_t cur;
  logic m_we;
  // target state
  s_state_t ss_q, ss_d;
  logic [3:0] sbit_q, sbit_d;
  logic [7:0] ssh_q, ssh_d, stx_q, stx_d, rxn_q, rxn_d;
  logic [4:0] sptr_q, sptr_d, rxf_q, rxf_d, rxl_q, rxl_d;
  logic s_sda_q, s_sda_d, nack_q, nack_d, act_q, act_d;
  logic first_q, first_d, whit_q, whit_d, s_we;
  logic scl_rise, scl_fall, start_det, stop_det;

  // two-flop synchronisers; edges look only at the second stage onward
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      {scl_a_q, scl_b_q, scl_c_q, sda_a_q, sda_b_q, sda_c_q} <= 6'h3F;
    end else begin
      {scl_a_q, scl_b_q, scl_c_q} <= {i_scl, scl_a_q, scl_b_q};
      {sda_a_q, sda_b_q, sda_c_q} <= {i_sda, sda_a_q, sda_b_q};
    end
  end
  assign scl_rise  = scl_b_q & ~scl_c_q;
  assign scl_fall  = ~scl_b_q & scl_c_q;
  assign start_det = scl_b_q & scl_c_q & ~sda_b_q & sda_c_q;
  assign stop_det  = scl_b_q & scl_c_q & sda_b_q & ~sda_c_q;

  // quarter-bit enable for the master's SCL phases
  assign tick = (qcnt_q == 8'(`SCL_QTR_CYC - 1));
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || tick) qcnt_q <= 8'h00;
    else qcnt_q <= qcnt_q + 8'h01;
  end

  assign cur = i_cmd_list[idx_q];

  // master sequencer
  always_comb begin
    {ms_d, ph_d, idx_d, bit_d, clr_d} = {ms_q, ph_q, idx_q, bit_q, clr_q};
    {cnt_d, sh_d, txn_d, wptr_d, rptr_d, txl_d} = {cnt_q, sh_q, txn_q, wptr_q, rptr_q, txl_q};
    {pend_d, ackv_d, m_scl_d, m_sda_d, fin_d} = {pend_q, ackv_q, m_scl_q, m_sda_q, fin_q};
    mev  = '0;
    m_we = 1'b0;
    if (i_begin_transaction) pend_d = 1'b1;
    if (tick) ph_d = ph_q + 2'h1;
    if (!i_master_mode) begin
      ms_d = M_IDLE;
      {m_scl_d, m_sda_d} = 2'b00;
    end else begin
      case (ms_q)
        M_IDLE: begin
          {m_scl_d, m_sda_d} = 2'b00;
          ph_d = `PH_DRIVE;
          if (pend_q && scl_b_q) begin
            {pend_d, idx_d, fin_d, wptr_d, rptr_d, txn_d} = '0;
            ms_d = M_START;
          end
        end
        M_PAUSE: begin
          m_scl_d = 1'b1;
          ph_d    = `PH_DRIVE;
          if (pend_q) begin
            {pend_d, idx_d, fin_d, wptr_d} = '0;
            ms_d = M_FETCH;
          end
        end
        M_FETCH: begin
          // one slot at a time; decode
          ph_d  = `PH_DRIVE;
          bit_d = 4'h0;
          case (cur.command_code)
            `OP_START: ms_d = M_START;
            `OP_WRITE, `OP_READ: begin
              cnt_d  = cur.byte_count;
              sh_d   = ram[wptr_q];
              wptr_d = wptr_q + 5'h01;
              ms_d   = M_BYTE;
            end
            `OP_END: begin
              fin_d[idx_q] = 1'b1;
              mev.pause_reached_event = 1'b1;
              ms_d = M_PAUSE;
            end
            default: ms_d = M_STOP;
          endcase
        end
        M_START: if (tick) begin
          case (ph_q)
            `PH_DRIVE: m_sda_d = 1'b0;
            `PH_RISE:  m_scl_d = 1'b0;
            `PH_HIGH: begin
              if (!scl_b_q) ph_d = ph_q;
              // target holds SDA, clock it free
              else if (!sda_b_q) begin
                ms_d  = M_CLEAR;
                ph_d  = `PH_DRIVE;
                clr_d = 4'h0;
              end else m_sda_d = 1'b1;
            end
            default: begin
              m_scl_d = 1'b1;
              fin_d[idx_q] = 1'b1;
              idx_d = idx_q + 4'h1;
              ms_d  = M_FETCH;
            end
          endcase
        end
        M_BYTE: if (tick) begin
          case (ph_q)
            `PH_DRIVE: begin
              m_scl_d = 1'b1;
              if (bit_q == `BIT_ACK)
                m_sda_d = (cur.command_code == `OP_READ) && !cur.ack_to_send;
              else m_sda_d = (cur.command_code != `OP_READ) && !sh_q[7];
            end
            `PH_RISE: m_scl_d = 1'b0;
            `PH_HIGH: begin
              if (!scl_b_q) ph_d = ph_q; // target stretches the clock
              else if (bit_q == `BIT_ACK) ackv_d = sda_b_q;
              else if (cur.command_code != `OP_READ && !m_sda_q && !sda_b_q) begin
                mev.arbitration_lost_event = 1'b1;
                {m_scl_d, m_sda_d} = 2'b00;
                ms_d = M_IDLE;
              end else sh_d = {sh_q[6:0], sda_b_q};
            end
            default: begin
              m_scl_d = 1'b1;
              bit_d   = bit_q + 4'h1;
              if (bit_q == `BIT_ACK) begin
                bit_d = 4'h0;
                if (cur.command_code == `OP_READ) begin
                  m_we   = 1'b1;
                  rptr_d = rptr_q + 5'h01;
                end else begin
                  txn_d = txn_q + 8'h01;
                  if (txn_q == i_tx_threshold) begin
                    mev.tx_drained_event = 1'b1;
                    txl_d = wptr_q - 5'h01;
                  end
                end
                if (cur.command_code != `OP_READ && cur.ack_compare_enable &&
                    ackv_q != cur.expected_ack) begin
                  mev.ack_mismatch_event = 1'b1;
                  ms_d = M_STOP;
                end else if (cnt_q == 8'h01) begin
                  fin_d[idx_q] = 1'b1;
                  idx_d = idx_q + 4'h1;
                  ms_d  = M_FETCH;
                end else begin
                  cnt_d  = cnt_q - 8'h01;
                  sh_d   = ram[wptr_q];
                  wptr_d = wptr_q + 5'h01;
                end
              end
            end
          endcase
        end
        M_STOP: if (tick) begin
          case (ph_q)
            `PH_DRIVE: {m_scl_d, m_sda_d} = 2'b11;
            `PH_RISE:  m_scl_d = 1'b0;
            `PH_HIGH: begin
              if (!scl_b_q) ph_d = ph_q;
              else m_sda_d = 1'b0;
            end
            default: begin
              mev.transfer_done_event = 1'b1;
              txl_d = wptr_q - 5'h01;
              fin_d[idx_q] = 1'b1;
              ms_d = M_IDLE;
            end
          endcase
        end
        M_CLEAR: if (tick) begin
          // at most nine pulses, then give up
          case (ph_q)
            `PH_DRIVE: {m_scl_d, m_sda_d} = 2'b10;
            `PH_RISE:  m_scl_d = 1'b0;
            `PH_HIGH: begin
              if (!scl_b_q) ph_d = ph_q;
              else if (sda_b_q) begin
                ms_d = M_START;
                ph_d = `PH_DRIVE;
              end
            end
            default: begin
              m_scl_d = 1'b1;
              clr_d   = clr_q + 4'h1;
              if (clr_q == `CLEAR_PULSES - 4'h1) ms_d = M_IDLE;
            end
          endcase
        end
        default: ms_d = M_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      {ms_q, ph_q, idx_q, bit_q, clr_q} <= {M_IDLE, 2'h0, 4'h0, 4'h0, 4'h0};
      {cnt_q, sh_q, txn_q, wptr_q, rptr_q, txl_q} <= '0;
      {pend_q, ackv_q, m_scl_q, m_sda_q, fin_q} <= '0;
    end else begin
      {ms_q, ph_q, idx_q, bit_q, clr_q} <= {ms_d, ph_d, idx_d, bit_d, clr_d};
      {cnt_q, sh_q, txn_q, wptr_q, rptr_q, txl_q} <= {cnt_d, sh_d, txn_d, wptr_d, rptr_d, txl_d};
      {pend_q, ackv_q, m_scl_q, m_sda_q, fin_q} <= {pend_d, ackv_d, m_scl_d, m_sda_d, fin_d};
    end
  end

  // addressed target, bit engine on synchronised SCL edges
  always_comb begin
    {ss_d, sbit_d, ssh_d, stx_d, rxn_d} = {ss_q, sbit_q, ssh_q, stx_q, rxn_q};
    {sptr_d, rxf_d, rxl_d} = {sptr_q, rxf_q, rxl_q};
    {s_sda_d, nack_d, act_d, first_d, whit_d} = {s_sda_q, nack_q, act_q, first_q, whit_q};
    sev  = '0;
    s_we = 1'b0;
    if (i_master_mode) begin
      ss_d    = S_IDLE;
      s_sda_d = 1'b0;
    end else if (start_det) begin
      ss_d    = S_ADDR;
      sbit_d  = 4'h0;
      s_sda_d = 1'b0;
    end else if (stop_det) begin
      if (act_q) begin
        sev.transfer_done_event = 1'b1;
        rxl_d = sptr_q - 5'h01;
      end
      {act_d, first_d, whit_d, s_sda_d} = 4'h0;
      ss_d = S_IDLE;
    end else if (ss_q != S_IDLE) begin
      if (scl_rise) begin
        if (sbit_q < `BIT_ACK) begin
          ssh_d  = {ssh_q[6:0], sda_b_q};
          sbit_d = sbit_q + 4'h1;
        end else if (ss_q == S_TX) nack_d = sda_b_q;
      end else if (scl_fall) begin
        if (sbit_q == `BIT_ACK) begin
          sbit_d  = `BIT_END;
          s_sda_d = 1'b0;
          case (ss_q)
            S_ADDR: begin
              if (i_wide_address_enable) begin
                if (ssh_q[7:3] == `WIDE_PREFIX && ssh_q[2:1] == i_own_target_address[9:8]
                    && (!ssh_q[0] || whit_q)) begin
                  s_sda_d = 1'b1;
                  ss_d    = ssh_q[0] ? S_TX : S_ADDR2;
                  nack_d  = 1'b0;
                  if (ssh_q[0] && !i_register_address_mode) sptr_d = 5'h00;
                end else ss_d = S_IDLE;
              end else if (ssh_q[7:1] == i_own_target_address[6:0]) begin
                s_sda_d = 1'b1;
                act_d   = 1'b1;
                nack_d  = 1'b0;
                rxn_d   = 8'h00;
                if (ssh_q[0]) ss_d = S_TX;
                else ss_d = i_register_address_mode ? S_REG : S_RX;
                if (!i_register_address_mode) sptr_d = 5'h00;
              end else ss_d = S_IDLE;
            end
            S_ADDR2: begin
              if (ssh_q == i_own_target_address[7:0]) begin
                {s_sda_d, act_d, whit_d} = 3'b111;
                rxn_d  = 8'h00;
                sptr_d = 5'h00;
                ss_d   = i_register_address_mode ? S_REG : S_RX;
              end else ss_d = S_IDLE;
            end
            S_REG: begin
              sptr_d  = ssh_q[4:0];
              s_sda_d = 1'b1;
              ss_d    = S_RX;
            end
            S_RX: begin
              // cap at 32 in register mode
              if (!(i_register_address_mode && rxn_q >= `REG_MAX_BYTES)) begin
                s_we    = 1'b1;
                s_sda_d = 1'b1;
                sptr_d  = sptr_q + 5'h01;
                rxn_d   = rxn_q + 8'h01;
                if (!first_q) begin
                  first_d = 1'b1;
                  rxf_d   = sptr_q;
                end
                if (rxn_q == i_rx_threshold) begin
                  sev.rx_filled_event = 1'b1;
                  rxl_d = sptr_q;
                end
              end
            end
            default: ;
          endcase
        end else if (sbit_q == `BIT_END) begin
          sbit_d  = 4'h0;
          s_sda_d = 1'b0;
          if (ss_q == S_TX) begin
            // send from ram at M, stop on nack
            if (nack_q) ss_d = S_IDLE;
            else begin
              stx_d   = ram[sptr_q];
              s_sda_d = !ram[sptr_q][7];
              sptr_d  = sptr_q + 5'h01;
            end
          end
        end else if (ss_q == S_TX) begin
          s_sda_d = !stx_q[6];
          stx_d   = {stx_q[6:0], 1'b0};
        end
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      {ss_q, sbit_q, ssh_q, stx_q, rxn_q} <= {S_IDLE, 4'h0, 8'h00, 8'h00, 8'h00};
      {sptr_q, rxf_q, rxl_q} <= '0;
      {s_sda_q, nack_q, act_q, first_q, whit_q} <= '0;
    end else begin
      {ss_q, sbit_q, ssh_q, stx_q, rxn_q} <= {ss_d, sbit_d, ssh_d, stx_d, rxn_d};
      {sptr_q, rxf_q, rxl_q} <= {sptr_d, rxf_d, rxl_d};
      {s_sda_q, nack_q, act_q, first_q, whit_q} <= {s_sda_d, nack_d, act_d, first_d, whit_d};
    end
  end

  // shared ram; bus writes win, a software write in that cycle is dropped
  always_ff @(posedge i_clk_sys) begin
    if (m_we) ram[rptr_q] <= sh_q;
    else if (s_we) ram[sptr_q] <= ssh_q;
    else if (i_ram_we) ram[i_ram_addr] <= i_ram_wdata;
    o_ram_rdata <= ram[i_ram_addr];
  end

  // registered pins and status
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      {o_scl_oe, o_sda_oe, o_busy} <= 3'b000;
      {o_cmd_finished, o_tx_last_address, o_rx_first_address, o_rx_last_address} <= '0;
      o_events <= '0;
    end else begin
      o_scl_oe           <= i_master_mode & m_scl_q;
      o_sda_oe           <= i_master_mode ? m_sda_q : s_sda_q;
      o_busy             <= (ms_q != M_IDLE);
      // next values, so status lines up with the event pulse that announces it
      o_cmd_finished     <= fin_d;
      o_tx_last_address  <= txl_d;
      o_rx_first_address <= rxf_d;
      o_rx_last_address  <= rxl_d;
      o_events           <= mev | sev;
    end
  end
endmodule // i2c_cmdseq

// ==== i2c_cmdseq_properties.sv ====
// concurrent checks on the ports of the command-sequenced controller
`timescale 1ns/1ps
`include "i2c_cmdseq_regs.svh"
module i2c_cmdseq_checker
  import i2c_cmdseq_pkg::*;
(
  // clock and reset
  input wire logic                 i_clk_sys,
  input wire logic                 i_rst,
  // control and lines
  input wire logic                 i_master_mode,
  input wire logic                 i_scl,
  input wire logic                 i_sda,
  input wire logic                 o_scl_oe,
  input wire logic                 o_sda_oe,
  // status
  input wire logic [`NUM_CMDS-1:0] o_cmd_finished,
  input wire events_t              o_events,
  input wire logic                 o_busy
);
  logic [7:0] mis_d;
  logic [7:0] mis_q;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  // history of released data line seen low with clock high; sync lag hides the cause
  always_comb begin
    mis_d = {mis_q[6:0], i_scl & !i_sda & !o_sda_oe};
  end
  always_ff @(posedge i_clk_sys) begin
    mis_q <= mis_d;
  end
  a_reset_quiet: // reset
    assert property (disable iff (1'b0) i_rst |=> !o_scl_oe && !o_sda_oe && !o_busy
      && o_events == '0) else $error("outputs active after reset");
  a_start_free:
    assert property ($rose(o_busy) |-> $past(i_scl, 2) || $past(i_scl, 3) || $past(i_scl, 4)
      || $past(i_scl, 5) || $past(i_scl, 6)) else $error("began with clock held low");
  a_arb_cause:
    assert property (o_events.arbitration_lost_event |-> mis_q != 8'h00)
      else $error("arbitration loss without line mismatch");
  a_arb_release:
    assert property (o_events.arbitration_lost_event |-> ##[0:3] (!o_scl_oe && !o_sda_oe))
      else $error("lines kept after arbitration loss");
  a_ack_halt:
    assert property (o_events.ack_mismatch_event && i_master_mode
      |-> ##[1:1000] o_events.transfer_done_event) else $error("no halt after ack mismatch");
  a_done_release:
    assert property (o_events.transfer_done_event && i_master_mode |-> !o_scl_oe && !o_sda_oe)
      else $error("done while lines held");
  a_done_finished:
    assert property (o_events.transfer_done_event && i_master_mode |-> o_cmd_finished[0])
      else $error("first slot not finished at done");
  a_pause_hold:
    assert property (o_events.pause_reached_event |-> o_scl_oe [*8])
      else $error("clock not held low in pause");
  a_pause_busy:
    assert property (o_events.pause_reached_event |=> o_busy && !o_events.transfer_done_event)
      else $error("bus given up at pause");
endmodule // i2c_cmdseq_checker
bind i2c_cmdseq i2c_cmdseq_checker u_i2c_cmdseq_checker (.i_clk_sys, .i_rst, .i_master_mode,
  .i_scl, .i_sda, .o_scl_oe, .o_sda_oe, .o_cmd_finished, .o_events, .o_busy);

// ==== i2c_far_target.sv ====
// far-side target model: acks, returns one read byte, can stall either line
`timescale 1ns/1ps
module i2c_far_target (
  // resolved lines
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  // test controls
  input  wire logic       i_nack,
  input  wire logic       i_hold_scl,
  input  wire logic       i_hold_sda,
  input  wire logic [7:0] i_rd_byte,
  // pull-downs and observations
  output logic            o_scl_low,
  output logic            o_sda_low,
  output logic [7:0]      o_addr_byte,
  output logic [7:0]      o_last_byte,
  output logic [3:0]      o_byte_cnt,
  output logic            o_mack
);
  logic       drv;
  logic       frame;
  logic       first;
  logic       rd;
  logic [3:0] bit_n;
  logic [7:0] sh;
  // open drain: a released line floats to the pull-up, never the last value
  assign o_sda_low = i_hold_sda | drv;
  assign o_scl_low = i_hold_scl;
  initial begin
    drv = 1'b0;
    frame = 1'b0;
    o_mack = 1'b0;
    o_byte_cnt = 4'h0;
  end
  // start and stop are data edges while the clock is high
  always @(negedge i_sda) begin
    if (i_scl) begin
      frame = 1'b1;
      first = 1'b1;
      rd = 1'b0;
      bit_n = 4'h0;
      o_byte_cnt = 4'h0;
    end
  end
  always @(posedge i_sda) begin
    if (i_scl) begin
      frame = 1'b0;
      drv = 1'b0;
    end
  end
  // shift in on rising clock; master ack slot of a read
  always @(posedge i_scl) begin
    if (frame && bit_n < 4'h8) begin
      sh = {sh[6:0], i_sda};
      bit_n = bit_n + 4'h1;
    end else if (frame && rd && !first) begin
      o_mack = i_sda;
    end
  end
  always @(negedge i_scl) begin
    if (frame && bit_n == 4'h8) begin
      bit_n = 4'h9;
      drv = 1'b0;
      if (!rd || first) begin
        o_last_byte = sh;
        o_byte_cnt = o_byte_cnt + 4'h1;
        drv = !i_nack;
        if (first) begin
          o_addr_byte = sh;
          rd = sh[0];
        end
      end
    end else if (frame && bit_n == 4'h9) begin
      bit_n = 4'h0;
      if (!first && o_mack) begin
        rd = 1'b0;
      end
      first = 1'b0;
      drv = rd && !i_rd_byte[7];
    end else if (frame && rd && !first) begin
      drv = !i_rd_byte[3'h7 - bit_n[2:0]];
    end
  end
endmodule // i2c_far_target

// ==== tb.sv ====
// self-checking bench for the command-sequenced two-wire controller
`timescale 1ns/1ps
`include "i2c_cmdseq_regs.svh"
module tb;
  import i2c_cmdseq_pkg::*;
  logic                 clk, rst, beg, we, nack, hs, hd, mack, busy;
  logic                 scl, sda, scl_oe, sda_oe, t_scl, t_sda;
  logic [4:0]           ra, txa;
  logic [7:0]           wd, rdb, rdata, ab, lb, txt;
  logic [3:0]           bc;
  cmd_t [`NUM_CMDS-1:0] cl;
  logic [`NUM_CMDS-1:0] fin;
  events_t              ev, seen;
  int                   n_mismatch, samples_checked, cyc;
  // wired-AND lines with pull-ups
  assign scl = !(scl_oe | t_scl);
  assign sda = !(sda_oe | t_sda);
  i2c_cmdseq u_i2c_cmdseq (.i_clk_sys(clk), .i_rst(rst), .i_master_mode(1'b1),
    .i_begin_transaction(beg), .i_cmd_list(cl), .i_tx_threshold(txt), .i_rx_threshold(8'h00),
    .i_own_target_address(10'h000), .i_wide_address_enable(1'b0),
    .i_register_address_mode(1'b0), .i_ram_we(we), .i_ram_addr(ra), .i_ram_wdata(wd),
    .o_ram_rdata(rdata), .i_scl(scl), .i_sda(sda), .o_scl_oe(scl_oe), .o_sda_oe(sda_oe),
    .o_cmd_finished(fin), .o_tx_last_address(txa), .o_rx_first_address(),
    .o_rx_last_address(), .o_events(ev), .o_busy(busy));
  i2c_far_target u_i2c_far_target (.i_scl(scl), .i_sda(sda), .i_nack(nack), .i_hold_scl(hs),
    .i_hold_sda(hd), .i_rd_byte(rdb), .o_scl_low(t_scl), .o_sda_low(t_sda), .o_addr_byte(ab),
    .o_last_byte(lb), .o_byte_cnt(bc), .o_mack(mack));
  // clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // sticky events, since they pulse for one cycle; run-length guard
  always @(posedge clk) begin
    seen <= seen | ev;
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_mismatch++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("mismatches %0d comparisons %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input bit ok, input string m);
    samples_checked++;
    if (!ok) begin
      n_mismatch++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(negedge clk);
    we = 1'b1;
    ra = a;
    wd = d;
    @(negedge clk);
    we = 1'b0;
  endtask
  // flags are {command_code, ack_to_send, expected_ack, ack_compare_enable}
  task automatic slot(input int i, input logic [5:0] f, input logic [7:0] n);
    cl[i] = {f, n};
  endtask
  task automatic pulse();
    @(negedge clk);
    seen = '0;
    beg = 1'b1;
    @(negedge clk);
    beg = 1'b0;
  endtask
  task automatic wait_ev(input events_t m);
    int k;
    k = 0;
    // stuck bus caught by a timeout, not a hang
    while ((seen & m) == '0 && k < 30000) begin
      @(negedge clk);
      k++;
    end
    repeat (4) @(negedge clk);
    chk(k < 30000, "no completion event");
  endtask
  task automatic t_write();
    wr(5'h00, 8'hA0);
    wr(5'h01, 8'h3C);
    slot(0, 6'h00, 8'h01);
    slot(1, 6'h08, 8'h02);
    slot(2, 6'h18, 8'h01);
    hs = 1'b1;
    pulse();
    repeat (400) @(negedge clk);
    chk(sda_oe === 1'b0 && busy === 1'b0, "start while clock held");
    hs = 1'b0;
    wait_ev(6'h02);
    chk(ab === 8'hA0 && lb === 8'h3C && bc === 4'h2, "written bytes");
    chk(seen.tx_drained_event === 1'b1 && txa === 5'h01, "tx threshold");
    chk(fin[3:0] === 4'h7, "finished bits");
  endtask
  task automatic t_nack();
    nack = 1'b1;
    slot(1, 6'h09, 8'h02);
    pulse();
    wait_ev(6'h02);
    chk(seen.ack_mismatch_event === 1'b1 && bc === 4'h1, "ack compare halt");
    nack = 1'b0;
  endtask
  task automatic t_pause();
    slot(1, 6'h08, 8'h01);
    slot(2, 6'h20, 8'h01);
    pulse();
    wait_ev(6'h01);
    repeat (400) @(negedge clk);
    chk(scl_oe === 1'b1 && busy === 1'b1 && seen.transfer_done_event === 1'b0, "pause");
    // END slot left in place, only slot 0 rewritten
    slot(0, 6'h18, 8'h01);
    pulse();
    wait_ev(6'h02);
    chk(scl_oe === 1'b0 && sda_oe === 1'b0 && fin[0] === 1'b1, "resume to stop");
  endtask
  task automatic t_read();
    wr(5'h00, 8'hA1);
    rdb = 8'h5A;
    slot(0, 6'h00, 8'h01);
    slot(2, 6'h14, 8'h01);
    slot(3, 6'h18, 8'h01);
    pulse();
    wait_ev(6'h02);
    ra = 5'h00;
    repeat (2) @(negedge clk);
    chk(rdata === 8'h5A, "read data at ram start");
    chk(mack === 1'b1, "nack on last read byte");
  endtask
  task automatic t_arb();
    int k;
    wr(5'h00, 8'hA0);
    slot(2, 6'h18, 8'h01);
    pulse();
    k = 0;
    while (scl_oe !== 1'b1 && k < 2000) begin
      @(negedge clk);
      k++;
    end
    hd = 1'b1;
    wait_ev(6'h06);
    chk(seen.arbitration_lost_event === 1'b1 && seen[1] === 1'b0 && busy === 1'b0, "arb");
    hd = 1'b0;
  endtask
  task automatic t_clear();
    hd = 1'b1;
    pulse();
    repeat (1500) @(negedge clk);
    chk(busy === 1'b1 && seen.transfer_done_event === 1'b0, "bus clear running");
    hd = 1'b0;
    wait_ev(6'h02);
    chk(ab === 8'hA0 && bc === 4'h1 && seen[2] === 1'b0, "start after bus clear");
  endtask
  // main sequence
  // byte counts stay within 1..255
  // short seven-bit lists, far below the length limit
  initial begin
    {rst, beg, we, nack, hs, hd} = 6'h20;
    {ra, wd, rdb, txt} = '0;
    seen = '0;
    cyc = 0;
    n_mismatch = 0;
    samples_checked = 0;
    for (int i = 0; i < `NUM_CMDS; i++) begin
      cl[i] = {6'h18, 8'h01};
    end
    repeat (5) @(negedge clk);
    rst = 1'b0;
    t_write();
    t_nack();
    t_pause();
    t_read();
    t_arb();
    t_clear();
    end_sim();
  end
endmodule // tb
